// ==== common/gppc_pkg.sv ====
// Purpose: Constants for the general-purpose register page and its pins.
// Assumes: 16-bit management registers, 5-bit register address.
// Notes:   Behaviour list below; offsets are page-local register numbers.
// Behaviour
// - Page value 0x0010 maps all addresses except 0x1F to page
// - Page value 0x0000 restores main page
// - Page registers hidden under any other page
// - Bit 13 active-low power-down pin enable
// - Bit 12 drives power-down pin when output
// - Bit 11 reads sampled power-down pin level
// - Bit 9 tri-states LED high level
// - Input register bits 1:0 read pins
// - Output register bits 1:0 drive pins
// - Direction bits 1:0, one means output
// - Bit 10 stores and returns written value
package gppc_pkg;
    localparam int           GPPC_AW           = 5;
    localparam int           GPPC_DW           = 16;
    localparam logic [4:0]   GPPC_PAGE_ADDR    = 5'h1F;
    localparam logic [15:0]  GPPC_PAGE_MAIN    = 16'h0000;
    localparam logic [15:0]  GPPC_PAGE_GENERAL = 16'h0010;
    localparam logic [4:0]   GPPC_PDC_ADDR     = 5'h0E;
    localparam logic [4:0]   GPPC_GIN_ADDR     = 5'h0F;
    localparam logic [4:0]   GPPC_GOUT_ADDR    = 5'h10;
    localparam logic [4:0]   GPPC_GDIR_ADDR    = 5'h11;
    localparam int           GPPC_PDC_OEN_BIT  = 13;
    localparam int           GPPC_PDC_OUT_BIT  = 12;
    localparam int           GPPC_PDC_IN_BIT   = 11;
    localparam int           GPPC_PDC_RSV_BIT  = 10;
    localparam int           GPPC_PDC_LEDT_BIT = 9;
    localparam logic         GPPC_PDC_OEN_RST  = 1'h1;
    localparam logic         GPPC_PDC_OUT_RST  = 1'h0;
    localparam logic         GPPC_PDC_RSV_RST  = 1'h0;
    localparam logic         GPPC_PDC_LEDT_RST = 1'h0;
    localparam int           GPPC_NPINS        = 2;
    localparam logic [1:0]   GPPC_GOUT_RST     = 2'h0;
    localparam logic [1:0]   GPPC_GDIR_RST     = 2'h0;
endpackage

// ==== rtl/gppc_top.sv ====
// Purpose: General-purpose register page with pin controls.
// Assumes: Pin inputs synchronous to mclk; reads answer one cycle later.
// Notes:   The main page lies outside; main_sel tells it to answer.
`timescale 1ns/1ps
module gppc_top
    import gppc_pkg::*;
#(
    parameter int NPINS = GPPC_NPINS
) (
    input  wire logic                          mclk,
    input  wire logic                          rstn,
    input  wire logic                          clk_en,
    input  wire logic [gppc_pkg::GPPC_AW-1:0]  addr,
    input  wire logic [gppc_pkg::GPPC_DW-1:0]  wdata,
    input  wire logic                          wr,
    input  wire logic                          rd,
    output logic      [gppc_pkg::GPPC_DW-1:0]  rdata,
    output logic                               main_sel,
    input  wire logic                          power_down_hold_pin_in,
    output logic                               power_down_hold_pin_out,
    output logic                               power_down_hold_pin_oe,
    output logic                               led_tristate,
    input  wire logic [NPINS-1:0]              gp_pin_in,
    output logic      [NPINS-1:0]              gp_pin_out,
    output logic      [NPINS-1:0]              gp_pin_oe
);
    import gppc_pkg::*;

    initial begin
        if (NPINS != GPPC_NPINS) begin
            $error("gppc_top: NPINS must be 2");
        end
    end

    logic [GPPC_DW-1:0] page;
    logic               pd_oen;
    logic               pd_rsv;
    logic               pd_in;
    logic [NPINS-1:0]   gp_in;
    logic               gen_sel;
    logic [GPPC_DW-1:0] next_rdata;

    assign gen_sel = (page == GPPC_PAGE_GENERAL);

    function automatic logic hit(input logic [GPPC_AW-1:0] a,
                                 input logic [GPPC_AW-1:0] r);
        hit = gen_sel && (a == r) && (a != GPPC_PAGE_ADDR);
    endfunction

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            page <= GPPC_PAGE_MAIN;
        end else if (clk_en && wr && addr == GPPC_PAGE_ADDR) begin
            page <= wdata;
        end
    end

    // Main-page flag is registered so it stays a flip-flop output.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            main_sel <= 1'b1;
        end else if (clk_en) begin
            main_sel <= !(wr && addr == GPPC_PAGE_ADDR) ? !gen_sel
                      : (wdata != GPPC_PAGE_GENERAL);
        end
    end

    // Power-down pin control register.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pd_oen                  <= GPPC_PDC_OEN_RST;
            power_down_hold_pin_oe  <= ~GPPC_PDC_OEN_RST;
            power_down_hold_pin_out <= GPPC_PDC_OUT_RST;
            pd_rsv                  <= GPPC_PDC_RSV_RST;
            led_tristate            <= GPPC_PDC_LEDT_RST;
        end else if (clk_en && wr && hit(addr, GPPC_PDC_ADDR)) begin
            pd_oen                  <= wdata[GPPC_PDC_OEN_BIT];
            power_down_hold_pin_oe  <= ~wdata[GPPC_PDC_OEN_BIT];
            power_down_hold_pin_out <= wdata[GPPC_PDC_OUT_BIT];
            pd_rsv                  <= wdata[GPPC_PDC_RSV_BIT];
            led_tristate            <= wdata[GPPC_PDC_LEDT_BIT];
        end
    end

    // General pin output and direction.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            gp_pin_out <= GPPC_GOUT_RST;
            gp_pin_oe  <= GPPC_GDIR_RST;
        end else if (clk_en && wr) begin
            if (hit(addr, GPPC_GOUT_ADDR)) begin
                gp_pin_out <= wdata[NPINS-1:0];
            end
            if (hit(addr, GPPC_GDIR_ADDR)) begin
                gp_pin_oe <= wdata[NPINS-1:0];
            end
        end
    end

    // Pins are synchronous, so one sampling stage suffices.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pd_in <= 1'b0;
            gp_in <= '0;
        end else if (clk_en) begin
            pd_in <= power_down_hold_pin_in;
            gp_in <= gp_pin_in;
        end
    end

    always_comb begin
        next_rdata = '0;
        if (addr == GPPC_PAGE_ADDR) begin
            next_rdata = page;
        end else if (hit(addr, GPPC_PDC_ADDR)) begin
            next_rdata[GPPC_PDC_OEN_BIT]  = pd_oen;
            next_rdata[GPPC_PDC_OUT_BIT]  = power_down_hold_pin_out;
            next_rdata[GPPC_PDC_IN_BIT]   = pd_in;
            next_rdata[GPPC_PDC_RSV_BIT]  = pd_rsv;
            next_rdata[GPPC_PDC_LEDT_BIT] = led_tristate;
        end else if (hit(addr, GPPC_GIN_ADDR)) begin
            next_rdata[NPINS-1:0] = gp_in;
        end else if (hit(addr, GPPC_GOUT_ADDR)) begin
            next_rdata[NPINS-1:0] = gp_pin_out;
        end else if (hit(addr, GPPC_GDIR_ADDR)) begin
            next_rdata[NPINS-1:0] = gp_pin_oe;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdata <= '0;
        end else if (clk_en) begin
            rdata <= rd ? next_rdata : '0;
        end
    end
endmodule

// ==== tb/gppc_board.sv ====
// Purpose: Board circuitry on the pins.
// Assumes: Board level shows only where the block does not drive.
// Notes:   Packed as {power-down pin, general pins}.
`timescale 1ns/1ps
module gppc_board (
    input  wire logic [2:0] oe,
    input  wire logic [2:0] dout,
    input  wire logic [2:0] ext,
    output logic      [2:0] pin
);
    assign pin = (oe & dout) | (~oe & ext);
endmodule

// ==== tb/gppc_chk_assertions.sv ====
// Purpose: Port checks for the general page.
// Assumes: clk_en held high by the bench.
// Notes:   Bound into gppc_top.
`timescale 1ns/1ps
module gppc_chk
    import gppc_pkg::*;
#(parameter int NPINS = 2) (
    input wire logic             mclk,
    input wire logic             rstn,
    input wire logic [4:0]       addr,
    input wire logic [15:0]      wdata,
    input wire logic             wr,
    input wire logic             rd,
    input wire logic [15:0]      rdata,
    input wire logic             main_sel,
    input wire logic             power_down_hold_pin_out,
    input wire logic             power_down_hold_pin_oe,
    input wire logic             led_tristate,
    input wire logic [NPINS-1:0] gp_pin_out,
    input wire logic [NPINS-1:0] gp_pin_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic pg;
    assign pg = wr && !main_sel;
    page_on_a: assert property (wr && addr == 5'h1F && wdata == 16'h0010
        |=> !main_sel) else $error("page not entered");
    page_off_a: assert property (wr && addr == 5'h1F && wdata == 16'h0
        |=> main_sel) else $error("main page not restored");
    page_hidden_a: assert property (wr && main_sel && addr == 5'h11
        |=> $stable(gp_pin_oe)) else $error("hidden write took effect");
    pd_enable_a: assert property (pg && addr == 5'h0E
        |=> power_down_hold_pin_oe == !$past(wdata[13])) else $error("pd oe");
    pd_value_a: assert property (pg && addr == 5'h0E
        |=> power_down_hold_pin_out == $past(wdata[12])) else $error("pd out");
    led_tri_a: assert property (pg && addr == 5'h0E
        |=> led_tristate == $past(wdata[9])) else $error("led tristate");
    gp_value_a: assert property (pg && addr == 5'h10
        |=> gp_pin_out == $past(wdata[1:0])) else $error("gp out");
    gp_dir_a: assert property (pg && addr == 5'h11
        |=> gp_pin_oe == $past(wdata[1:0])) else $error("gp dir");
    gin_rsv_a: assert property (rd && !main_sel && addr == 5'h0F
        |=> rdata[15:2] == 14'h0) else $error("reserved bits set");
endmodule
bind gppc_top gppc_chk #(.NPINS(NPINS)) chk (.*);

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the general page.
// Assumes: Reads checked by a queue of expected words.
// Notes:   clk_en tied high.
`timescale 1ns/1ps
module testbench;
    logic mclk, rstn, wr, rd, pend, p;
    logic [4:0] addr;
    logic [15:0] wdata, rdata, v, q[$];
    logic main_sel, power_down_hold_pin_out, power_down_hold_pin_oe;
    logic led_tristate;
    logic [1:0] gp_pin_out, gp_pin_oe, g;
    logic [2:0] ext, pin, e;
    int n_errors = 0;
    int cmp_count = 0;
    gppc_top DUT (.*, .clk_en(1'b1), .power_down_hold_pin_in(pin[2]),
        .gp_pin_in(pin[1:0]));
    gppc_board B (.oe({power_down_hold_pin_oe, gp_pin_oe}),
        .dout({power_down_hold_pin_out, gp_pin_out}), .ext(ext), .pin(pin));
    task automatic summarize;
        if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wr_t(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk);
        wr <= 1; addr <= a; wdata <= d;
        @(posedge mclk);
        wr <= 0;
    endtask
    task automatic rd_t(input logic [4:0] a, input logic [15:0] x);
        @(posedge mclk);
        rd <= 1; addr <= a; q.push_back(x);
        @(posedge mclk);
        rd <= 0;
    endtask
    always @(posedge mclk) pend <= rd;
    always @(negedge mclk) begin
        cmp_count++;
        if (rdata !== (pend ? q.pop_front() : 16'h0)) begin
            n_errors++;
            $display("BAD %0t read data mismatch", $time);
        end
    end
    initial begin
        mclk = 0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        #100000 n_errors++;
        summarize();
    end
    initial begin
        rstn = 0; wr = 0; rd = 0; addr = 0; wdata = 0; ext = 0;
        void'($urandom(32'h7AF5));
        repeat (5) @(posedge mclk);
        rstn <= 1;
        rd_t(5'h0E, 16'h0000);
        wr_t(5'h11, 16'h0003);
        rd_t(5'h1F, 16'h0000);
        wr_t(5'h1F, 16'h0010);
        rd_t(5'h1F, 16'h0010);
        rd_t(5'h11, 16'h0000);
        rd_t(5'h0E, 16'h2000);
        for (int i = 0; i < 8; i++) begin
            v = 16'($urandom);
            e = 3'($urandom);
            ext <= e;
            wr_t(5'h0E, v);
            wr_t(5'h10, v);
            wr_t(5'h11, v >> 4);
            p = v[13] ? e[2] : v[12];
            g = (v[5:4] & v[1:0]) | (~v[5:4] & e[1:0]);
            rd_t(5'h0E, (v & 16'h3600) | {4'h0, p, 11'h0});
            rd_t(5'h0F, {14'h0, g});
            rd_t(5'h10, {14'h0, v[1:0]});
            rd_t(5'h11, {14'h0, v[5:4]});
            rd_t(5'h03, 16'h0000);
        end
        wr_t(5'h1F, 16'h0000);
        rd_t(5'h10, 16'h0000);
        wr_t(5'h10, ~v);
        wr_t(5'h1F, 16'h0010);
        rd_t(5'h10, {14'h0, v[1:0]});
        repeat (3) @(posedge mclk);
        summarize();
    end
endmodule
